// ### service_port_pkg.sv
// package with frame constants and carrier types for the service port uart
// Function
// RULE1: wired port uses fixed frame: 38.4 kbps, 7 data, even parity, 2 stop.
// RULE2: infrared port uses the same fixed frame as the wired port.
// RULE3: controller answers as unit 01; host addresses unit 01 with matching frame.
// RULE4: only one service path, infrared or wired, carries the link at a time.
// RULE5: infrared path usable only while the infrared-use setting is on; the code keeps it after turn-off until rx and tx are both idle.
// RULE6: infrared lamp lit while the setting is on, dark when off.
// RULE7: host should turn the infrared-use setting off after transfers.
// RULE8: characters with parity or stop-bit errors are discarded and flagged.
package service_port_pkg;
  localparam int unsigned CLK_HZ = 100000000;
  localparam int unsigned BAUD_BPS = 38400;
  localparam int unsigned BIT_CYC = (CLK_HZ + BAUD_BPS / 2) / BAUD_BPS;
  localparam int unsigned HALF_CYC = BIT_CYC / 2;
  localparam int unsigned DATA_BITS = 7;
  localparam int unsigned STOP_BITS = 2;
  localparam logic [7:0] UNIT_NO = 8'h01;
  localparam logic [11:0] CNT_RST = 12'h000;
  localparam logic [3:0] BIT_RST = 4'h0;

  typedef struct packed {
    logic valid;
    logic [6:0] data;
  } char_t;

  typedef struct packed {
    logic valid;
    logic par_err;
    logic stop_err;
  } rx_stat_t;
endpackage

// ### service_port_uart.sv
// service port uart with wired and infrared paths sharing one fixed frame
`timescale 1ns/1ps
module service_port_uart
  import service_port_pkg::*;
(
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic ir_enable_i,
  input wire logic wired_rxd_i,
  input wire logic ir_rxd_i,
  input wire service_port_pkg::char_t tx_char_i,
  output logic tx_ready_o,
  output logic wired_txd_o,
  output logic ir_txd_o,
  output service_port_pkg::char_t rx_char_o,
  output service_port_pkg::rx_stat_t rx_err_o,
  output logic infrared_link_lamp_o,
  output logic ir_active_o,
  output logic [7:0] unit_no_o
);
  typedef enum logic [3:0] {
    TX_IDLE = 4'b0001, TX_SHIFT = 4'b0010
  } tx_state_t;
  typedef enum logic [3:0] {
    RX_IDLE = 4'b0001, RX_SHIFT = 4'b0010
  } rx_state_t;

  localparam logic [11:0] BIT_C = 12'(BIT_CYC - 1);
  localparam logic [11:0] HALF_C = 12'(HALF_CYC - 1);
  // start + 7 data + parity + 2 stop
  localparam logic [3:0] FRAME_LEN = 4'(DATA_BITS + STOP_BITS + 2);
  // cycles spent shifting one whole frame
  localparam logic [15:0] FRAME_C = 16'(BIT_CYC * (DATA_BITS + STOP_BITS + 2));

  logic [1:0] wsync_q, isync_q, esync_q;
  logic [1:0] wsync_d, isync_d, esync_d;
  logic ir_sel_q, ir_sel_d;
  logic busy;
  always_comb begin
    wsync_d = {wsync_q[0], wired_rxd_i};
    isync_d = {isync_q[0], ir_rxd_i};
    esync_d = {esync_q[0], ir_enable_i};
    ir_sel_d = ir_sel_q;
    // path switches only between characters
    if (!busy) ir_sel_d = esync_q[1]; // RULE4 RULE5
  end
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      wsync_q <= 2'h3;
      isync_q <= 2'h3;
      esync_q <= 2'h0;
      ir_sel_q <= 1'b0;
    end else begin
      wsync_q <= wsync_d;
      isync_q <= isync_d;
      esync_q <= esync_d;
      ir_sel_q <= ir_sel_d;
    end
  end

  // one shared receive line, selected path only
  logic rxd;
  assign rxd = ir_sel_q ? isync_q[1] : wsync_q[1]; // RULE4

  // transmitter
  tx_state_t tx_st_q, tx_st_d;
  logic [11:0] tx_cnt_q, tx_cnt_d;
  logic [3:0] tx_bit_q, tx_bit_d;
  logic [10:0] tx_sh_q, tx_sh_d;
  logic tx_line;
  always_comb begin
    tx_st_d = tx_st_q;
    tx_cnt_d = tx_cnt_q;
    tx_bit_d = tx_bit_q;
    tx_sh_d = tx_sh_q;
    unique case (tx_st_q)
      TX_IDLE: begin
        if (tx_char_i.valid) begin
          // stop, stop, even parity, data lsb first, start
          tx_sh_d = {2'b11, ^tx_char_i.data, tx_char_i.data, 1'b0}; // RULE1 RULE2
          tx_cnt_d = BIT_C;
          tx_bit_d = BIT_RST;
          tx_st_d = TX_SHIFT;
        end
      end
      TX_SHIFT: begin
        if (tx_cnt_q == CNT_RST) begin
          tx_cnt_d = BIT_C;
          tx_sh_d = {1'b1, tx_sh_q[10:1]};
          tx_bit_d = tx_bit_q + 4'h1;
          if (tx_bit_q == FRAME_LEN - 4'h1) tx_st_d = TX_IDLE;
        end else begin
          tx_cnt_d = tx_cnt_q - 12'h001;
        end
      end
      default: tx_st_d = TX_IDLE;
    endcase
  end
  assign tx_line = (tx_st_q == TX_SHIFT) ? tx_sh_q[0] : 1'b1;
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      tx_st_q <= TX_IDLE;
      tx_cnt_q <= CNT_RST;
      tx_bit_q <= BIT_RST;
      tx_sh_q <= 11'h7FF;
      tx_ready_o <= 1'b0;
      wired_txd_o <= 1'b1;
      ir_txd_o <= 1'b1;
      infrared_link_lamp_o <= 1'b0;
      ir_active_o <= 1'b0;
      unit_no_o <= 8'h00;
    end else begin
      tx_st_q <= tx_st_d;
      tx_cnt_q <= tx_cnt_d;
      tx_bit_q <= tx_bit_d;
      tx_sh_q <= tx_sh_d;
      tx_ready_o <= (tx_st_d == TX_IDLE);
      wired_txd_o <= ir_sel_q ? 1'b1 : tx_line; // RULE4
      ir_txd_o <= ir_sel_q ? tx_line : 1'b1; // RULE5
      infrared_link_lamp_o <= esync_q[1]; // RULE6
      ir_active_o <= ir_sel_q;
      unit_no_o <= UNIT_NO; // RULE3
    end
  end

  // receiver
  rx_state_t rx_st_q, rx_st_d;
  logic [11:0] rx_cnt_q, rx_cnt_d;
  logic [3:0] rx_bit_q, rx_bit_d;
  logic [9:0] rx_sh_q, rx_sh_d;
  char_t rx_char_d;
  rx_stat_t rx_err_d;
  logic [9:0] fr;
  always_comb begin
    rx_st_d = rx_st_q;
    rx_cnt_d = rx_cnt_q;
    rx_bit_d = rx_bit_q;
    rx_sh_d = rx_sh_q;
    rx_char_d = '0;
    rx_err_d = '0;
    fr = {rxd, rx_sh_q[9:1]};
    unique case (rx_st_q)
      RX_IDLE: begin
        if (!rxd) begin
          rx_cnt_d = HALF_C;
          rx_bit_d = BIT_RST;
          rx_st_d = RX_SHIFT;
        end
      end
      RX_SHIFT: begin
        if (rx_cnt_q == CNT_RST) begin
          rx_cnt_d = BIT_C;
          rx_bit_d = rx_bit_q + 4'h1;
          if (rx_bit_q == 4'h0 && rxd) begin
            rx_st_d = RX_IDLE; // false start
          end else if (rx_bit_q != 4'h0) begin
            rx_sh_d = fr;
          end
          if (rx_bit_q == FRAME_LEN - 4'h1) begin
            rx_st_d = RX_IDLE;
            // fr: [9:8] stop, [7] parity, [6:0] data
            rx_err_d.par_err = ^fr[7:0]; // RULE8
            rx_err_d.stop_err = ~&fr[9:8]; // RULE8
            rx_err_d.valid = rx_err_d.par_err | rx_err_d.stop_err;
            rx_char_d.valid = ~rx_err_d.valid; // RULE8
            rx_char_d.data = rx_err_d.valid ? 7'h00 : fr[6:0];
          end
        end else begin
          rx_cnt_d = rx_cnt_q - 12'h001;
        end
      end
      default: rx_st_d = RX_IDLE;
    endcase
  end
  assign busy = (rx_st_q != RX_IDLE) || (tx_st_q != TX_IDLE);
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      rx_st_q <= RX_IDLE;
      rx_cnt_q <= CNT_RST;
      rx_bit_q <= BIT_RST;
      rx_sh_q <= 10'h000;
      rx_char_o <= '0;
      rx_err_o <= '0;
    end else begin
      rx_st_q <= rx_st_d;
      rx_cnt_q <= rx_cnt_d;
      rx_bit_q <= rx_bit_d;
      rx_sh_q <= rx_sh_d;
      rx_char_o <= rx_char_d;
      rx_err_o <= rx_err_d;
    end
  end

  // cycle count of the frame in flight, for the length checks
  logic [15:0] tx_len_q, tx_len_d;
  always_comb begin
    tx_len_d = (tx_st_q == TX_SHIFT) ? tx_len_q + 16'h0001 : 16'h0000;
  end
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      tx_len_q <= 16'h0000;
    end else begin
      tx_len_q <= tx_len_d;
    end
  end

  lamp_follows_a: assert property (@(posedge mclk_i) disable iff (!nrst_i) // RULE6
    esync_q[1] |=> infrared_link_lamp_o) else $error("lamp not lit");
  ir_idle_off_a: assert property (@(posedge mclk_i) disable iff (!nrst_i) // RULE5
    !ir_sel_q |=> ir_txd_o) else $error("ir driven while off");
  one_path_a: assert property (@(posedge mclk_i) disable iff (!nrst_i) // RULE4
    !(ir_active_o && !wired_txd_o)) else $error("both paths active");
  wired_quiet_a: assert property (@(posedge mclk_i) disable iff (!nrst_i) // RULE4
    ir_sel_q |=> wired_txd_o) else $error("wired driven in ir mode");
  start_bit_a: assert property (@(posedge mclk_i) disable iff (!nrst_i) // RULE1
    (tx_st_q == TX_IDLE && tx_char_i.valid) |=> ##1 !tx_line)
    else $error("no start bit");
  tx_len_a: assert property (@(posedge mclk_i) disable iff (!nrst_i) // RULE2
    (tx_st_q == TX_SHIFT && tx_st_d == TX_IDLE) |-> tx_len_q == FRAME_C - 16'h0001)
    else $error("frame length wrong");
  tx_no_hang_a: assert property (@(posedge mclk_i) disable iff (!nrst_i) // RULE1
    (tx_st_q == TX_SHIFT) |-> tx_len_q < FRAME_C)
    else $error("frame overruns");
  unit_no_a: assert property (@(posedge mclk_i) disable iff (!nrst_i) // RULE3
    $past(nrst_i) |-> unit_no_o == UNIT_NO) else $error("unit not 01");
  err_drop_a: assert property (@(posedge mclk_i) disable iff (!nrst_i) // RULE8
    rx_err_o.valid |-> !rx_char_o.valid) else $error("bad char passed");
  err_cause_a: assert property (@(posedge mclk_i) disable iff (!nrst_i) // RULE8
    rx_err_o.valid |-> (rx_err_o.par_err || rx_err_o.stop_err))
    else $error("error without cause");
endmodule

// ### sp_pc_model.sv
// host serial model for the fixed service frame
`timescale 1ns/1ps
module sp_pc_model
  import service_port_pkg::*;
(
  input wire logic mclk_i,
  input wire logic txd_i,
  output logic rxd_o
);
  logic [10:0] f;
  initial rxd_o = 1'b1;
  // bad flips parity and drops both stop bits
  task automatic send(input logic [6:0] d, input logic bad);
    f = {~bad, ~bad, (^d) ^ bad, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rxd_o = f[i];
      repeat (BIT_CYC) @(posedge mclk_i);
      #1;
    end
    rxd_o = 1'b1;
  endtask
  task automatic get(output logic [6:0] d, output logic ok);
    logic [10:0] r;
    // look just after each edge, once the registered line has settled
    do begin
      @(posedge mclk_i);
      #1;
    end while (txd_i !== 1'b0);
    repeat (HALF_CYC) @(posedge mclk_i);
    #1;
    for (int i = 0; i < 11; i++) begin
      r[i] = txd_i;
      repeat (BIT_CYC) @(posedge mclk_i);
      #1;
    end
    d = r[7:1];
    ok = (r[0] === 1'b0) && (r[8] === ^r[7:1]) && (r[10:9] === 2'b11);
  endtask
endmodule

// ### service_port_uart_tb.sv
// testbench for the service port uart
`timescale 1ns/1ps
module service_port_uart_tb
  import service_port_pkg::*;
;
  logic mclk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic ir_enable_i = 1'b0;
  char_t tx_char_i = '0;
  logic tx_ready_o, wired_txd_o, ir_txd_o, infrared_link_lamp_o, ir_active_o;
  logic wired_rxd_i, ir_rxd_i, w_low, i_low, tok;
  char_t rx_char_o;
  rx_stat_t rx_err_o;
  logic [7:0] unit_no_o;
  logic [6:0] got, td;
  logic [2:0] stat;
  int err_count = 0, checks = 0, cyc = 0, n_ok = 0, n_bad = 0;
  service_port_uart DUT (.mclk_i(mclk_i), .nrst_i(nrst_i), .ir_enable_i(ir_enable_i),
    .wired_rxd_i(wired_rxd_i), .ir_rxd_i(ir_rxd_i), .tx_char_i(tx_char_i),
    .tx_ready_o(tx_ready_o), .wired_txd_o(wired_txd_o), .ir_txd_o(ir_txd_o),
    .rx_char_o(rx_char_o), .rx_err_o(rx_err_o), .infrared_link_lamp_o(infrared_link_lamp_o),
    .ir_active_o(ir_active_o), .unit_no_o(unit_no_o));
  sp_pc_model pc_w (.mclk_i(mclk_i), .txd_i(wired_txd_o), .rxd_o(wired_rxd_i));
  sp_pc_model pc_ir (.mclk_i(mclk_i), .txd_i(ir_txd_o), .rxd_o(ir_rxd_i));
  initial forever #5 mclk_i = ~mclk_i;
  task automatic results();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (rx_char_o.valid === 1'b1) begin
      n_ok <= n_ok + 1;
      got <= rx_char_o.data;
    end
    if (rx_err_o.valid === 1'b1) begin
      n_bad <= n_bad + 1;
      stat <= rx_err_o;
    end
    if (wired_txd_o === 1'b0) w_low <= 1'b1;
    if (ir_txd_o === 1'b0) i_low <= 1'b1;
    if (cyc == 70000) begin
      err_count++;
      results();
    end
  end
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic put(input logic [6:0] d);
    do begin
      @(posedge mclk_i);
      #1;
    end while (tx_ready_o !== 1'b1);
    tx_char_i = {1'b1, d};
    @(posedge mclk_i);
    #1;
    tx_char_i.valid = 1'b0;
  endtask
  // full duplex on the selected path, noise char on the other
  task automatic duplex(input logic ir, input logic [6:0] dr, input logic bad,
                        input logic [6:0] dt);
    n_ok = 0;
    n_bad = 0;
    w_low = 0;
    i_low = 0;
    fork
      if (ir) pc_ir.send(dr, bad); else pc_w.send(dr, bad);
      if (ir) pc_w.send(~dr, 1'b0); else pc_ir.send(~dr, 1'b0);
      put(dt);
      if (ir) pc_ir.get(td, tok); else pc_w.get(td, tok);
    join
  endtask
  task automatic t_reset();
    chk("unit_no", unit_no_o, 8'h01);
    chk("lamp", 8'(infrared_link_lamp_o), 8'h00);
    chk("ready", 8'(tx_ready_o), 8'h01);
    $display("t_reset done");
  endtask
  task automatic t_wired();
    duplex(1'b0, 7'h55, 1'b0, 7'h2A);
    chk("rx_count", 8'(n_ok), 8'h01);
    chk("rx_data", 8'(got), 8'h55);
    chk("ir_rx_ignored", 8'(n_bad), 8'h00);
    chk("tx_data", 8'(td), 8'h2A);
    chk("tx_frame", 8'(tok), 8'h01);
    chk("ir_txd_idle", 8'(i_low), 8'h00);
    $display("t_wired done");
  endtask
  task automatic t_ir();
    ir_enable_i = 1'b1;
    repeat (6) @(posedge mclk_i);
    #1;
    chk("lamp_on", 8'(infrared_link_lamp_o), 8'h01);
    chk("ir_active", 8'(ir_active_o), 8'h01);
    duplex(1'b1, 7'h3C, 1'b1, 7'h41);
    chk("bad_discard", 8'(n_ok), 8'h00);
    chk("bad_flag", 8'(n_bad), 8'h01);
    chk("bad_stat", 8'(stat), 8'h07);
    chk("ir_tx_data", 8'(td), 8'h41);
    chk("ir_tx_frame", 8'(tok), 8'h01);
    chk("wired_txd_idle", 8'(w_low), 8'h00);
    $display("t_ir done");
  endtask
  task automatic t_off();
    ir_enable_i = 1'b0;
    repeat (6) @(posedge mclk_i);
    #1;
    chk("lamp_off", 8'(infrared_link_lamp_o), 8'h00);
    chk("wired_back", 8'(ir_active_o), 8'h00);
    $display("t_off done");
  endtask
  // reset in mid-run with the infrared setting on
  task automatic t_rst_mid();
    ir_enable_i = 1'b1;
    nrst_i = 1'b0;
    repeat (6) @(posedge mclk_i);
    #1;
    chk("rst_ready", 8'(tx_ready_o), 8'h00);
    chk("rst_lamp", 8'(infrared_link_lamp_o), 8'h00);
    chk("rst_unit", unit_no_o, 8'h00);
    nrst_i = 1'b1;
    repeat (4) @(posedge mclk_i);
    #1;
    chk("rel_lamp", 8'(infrared_link_lamp_o), 8'h01);
    chk("rel_ir_active", 8'(ir_active_o), 8'h01);
    chk("rel_unit", unit_no_o, 8'h01);
    ir_enable_i = 1'b0;
    repeat (6) @(posedge mclk_i);
    #1;
    chk("rel_lamp_off", 8'(infrared_link_lamp_o), 8'h00);
    $display("t_rst_mid done");
  endtask
  initial begin
    repeat (6) @(posedge mclk_i);
    #1;
    nrst_i = 1'b1;
    repeat (4) @(posedge mclk_i);
    #1;
    t_reset();
    t_wired();
    t_ir();
    t_off();
    t_rst_mid();
    results();
  end
endmodule
